// file: core/cmm_core.sv
// executor for the move, literal load, store and literal multiply instructions
// Summary of operation
// - long move: three cycles; idle, read source, write destination in Q4, no dummy read
// - long move reaches all 14-bit addresses, copies byte unchanged, no flags
// - literal_to_bank_select loads 6-bit literal into bank select low bits
// - bank select bits 7 and 6 always read zero
// - bank select load: decode Q1, literal Q2, process Q3, write Q4
// - literal_to_working_reg loads 8-bit literal into W, flags untouched
// - working register load: literal Q2, process Q3, write W Q4
// - store_working_reg writes W to file; bank bit picks access bank or bank select
// - bank bit 0 with extended set: indexed offset for addresses up to 5Fh
// - store: read W Q2, process Q3, write file Q4, one cycle, no flags
// - literal_multiply: W times literal unsigned, 16-bit product, W unchanged
// - literal multiply changes no flag; zero product not flagged
// - product high byte in high register, low byte in low register
// - multiply: literal Q2, process Q3, write both product registers Q4
`timescale 1ns/1ps

module cmm_core (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // instruction word, offered in Q1
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    // configuration and indexed base from the core
    input wire logic ext_set_en_i,
    input wire logic [13:0] idx_base_i,
    // data memory
    output cmm_pkg::cmm_mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    // architectural registers and status
    output logic [7:0] w_o,
    output logic [7:0] bsr_o,
    output logic [7:0] prod_hi_o,
    output logic [7:0] prod_lo_o,
    output logic [1:0] q_phase_o,
    output logic busy_o,
    output logic unknown_o
);

    cmm_pkg::cmm_state_t s_r;
    cmm_pkg::cmm_state_t s_nxt;

    // file address of a byte-oriented operand
    function automatic logic [13:0] file_addr(
        input logic [7:0] f,
        input logic a,
        input logic [7:0] bank_select_register,
        input logic ext,
        input logic [13:0] base
    );
        logic [13:0] res;
        res = 14'h0000;
        if (a) begin
            res = {bank_select_register[5:0], f};
        end else if (ext && (f <= cmm_pkg::IDX_LIMIT)) begin
            res = base + {6'h00, f};
        end else if (f < cmm_pkg::ACC_SPLIT) begin
            res = {cmm_pkg::ACC_LO_PAGE, f};
        end else begin
            res = {cmm_pkg::ACC_HI_PAGE, f};
        end
        return res;
    endfunction : file_addr

    // long-move source or destination that names W itself
    function automatic logic is_w_addr(
        input logic [13:0] a
    );
        return a == cmm_pkg::W_ADDR;
    endfunction : is_w_addr

    // continuation word of the long move, offered and tagged 1111
    function automatic logic is_cont_word(
        input logic valid,
        input logic [15:0] wd
    );
        return valid && (wd[15:12] == cmm_pkg::OPC_MVCONT);
    endfunction : is_cont_word

    // single-word opcode decode; OP_NONE stands for a refused word
    function automatic cmm_pkg::cmm_op_t decode_word(
        input logic [15:0] wd
    );
        cmm_pkg::cmm_op_t res;
        res = cmm_pkg::OP_NONE;
        if (wd[15:8] == cmm_pkg::OPC_LBSR) begin
            // literal above 63 is not a legal bank number
            if (wd[7:6] == 2'h0) begin
                res = cmm_pkg::OP_LBSR;
            end
        end else if (wd[15:8] == cmm_pkg::OPC_LWREG) begin
            res = cmm_pkg::OP_LWREG;
        end else if (wd[15:8] == cmm_pkg::OPC_LMUL) begin
            res = cmm_pkg::OP_LMUL;
        end else if (wd[15:9] == cmm_pkg::OPC_SWREG) begin
            res = cmm_pkg::OP_SWREG;
        end else begin
            res = cmm_pkg::OP_NONE;
        end
        return res;
    endfunction : decode_word

    // unsigned 8 by 8 product; the full 16 bits cannot overflow
    function automatic logic [15:0] mul_u8(
        input logic [7:0] a,
        input logic [7:0] b
    );
        logic [15:0] res;
        res = {8'h00, a} * {8'h00, b};
        return res;
    endfunction : mul_u8

    // bank select value with the top two bits forced low
    function automatic logic [7:0] bank_value(
        input logic [7:0] lit
    );
        return {2'h0, lit[5:0]};
    endfunction : bank_value

    // operand taken in Q2 for a single-word instruction
    function automatic logic [7:0] q2_operand(
        input cmm_pkg::cmm_op_t op,
        input logic [7:0] lit,
        input logic [7:0] w
    );
        logic [7:0] res;
        res = lit;
        if (op == cmm_pkg::OP_SWREG) begin
            res = w;
        end
        return res;
    endfunction : q2_operand

    // next-state logic, stepped by quarter phase
    always_comb begin
        s_nxt = s_r;
        s_nxt.q = s_r.q + 2'h1;
        s_nxt.unknown = 1'b0;
        case (s_r.q)
            // decode
            cmm_pkg::Q1: begin
                s_nxt.op = cmm_pkg::OP_NONE;
                if (s_r.mv == cmm_pkg::MV_WORD2) begin
                    // second word: rest of source, top of destination
                    if (is_cont_word(instr_valid_i, instr_i)) begin
                        s_nxt.src = {s_r.src[13:10], instr_i[11:2]};
                        s_nxt.dst = {instr_i[1:0], 12'h000};
                        s_nxt.op = cmm_pkg::OP_MVRD;
                        s_nxt.mem.addr = {s_r.src[13:10], instr_i[11:2]};
                        s_nxt.mem.rd = !is_w_addr({s_r.src[13:10], instr_i[11:2]});
                    end else begin
                        s_nxt.mv = cmm_pkg::MV_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.unknown = 1'b1;
                    end
                end else if (s_r.mv == cmm_pkg::MV_WORD3) begin
                    // third word: rest of destination, no read
                    if (is_cont_word(instr_valid_i, instr_i)) begin
                        s_nxt.dst = {s_r.dst[13:12], instr_i[11:0]};
                        s_nxt.op = cmm_pkg::OP_MVWR;
                    end else begin
                        s_nxt.mv = cmm_pkg::MV_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.unknown = 1'b1;
                    end
                end else if (instr_valid_i) begin
                    s_nxt.lit = instr_i[7:0];
                    if (instr_i[15:4] == cmm_pkg::OPC_MV1) begin
                        // first word: nothing happens but capture
                        s_nxt.src = {instr_i[3:0], 10'h000};
                        s_nxt.mv = cmm_pkg::MV_WORD2;
                        s_nxt.busy = 1'b1;
                    end else begin
                        // single-word instruction, or a refused word
                        s_nxt.op = decode_word(instr_i);
                        if (decode_word(instr_i) == cmm_pkg::OP_NONE) begin
                            s_nxt.unknown = 1'b1;
                        end
                        // store address fixed at decode from bank select and mode
                        if (decode_word(instr_i) == cmm_pkg::OP_SWREG) begin
                            s_nxt.dst = file_addr(instr_i[7:0], instr_i[8], s_r.bank_select_register,
                                ext_set_en_i, idx_base_i);
                        end
                    end
                end
            end
            // read operand
            cmm_pkg::Q2: begin
                s_nxt.mem.rd = 1'b0;
                case (s_r.op)
                    cmm_pkg::OP_LBSR, cmm_pkg::OP_LWREG,
                    cmm_pkg::OP_LMUL, cmm_pkg::OP_SWREG: begin
                        s_nxt.data = q2_operand(s_r.op, s_r.lit, s_r.w);
                    end
                    cmm_pkg::OP_MVRD: begin
                        // source read; W itself served without memory
                        if (is_w_addr(s_r.src)) begin
                            s_nxt.data = s_r.w;
                        end else begin
                            s_nxt.data = mem_rdata_i;
                        end
                        s_nxt.mv = cmm_pkg::MV_WORD3;
                    end
                    default: begin
                        s_nxt.data = s_r.data;
                    end
                endcase
            end
            // process data
            cmm_pkg::Q3: begin
                case (s_r.op)
                    cmm_pkg::OP_LMUL: begin
                        // product formed here, held until the Q4 write
                        s_nxt.prod = mul_u8(s_r.w, s_r.data);
                    end
                    cmm_pkg::OP_SWREG: begin
                        // strobe raised so it stands for the whole Q4
                        s_nxt.mem.addr = s_r.dst;
                        s_nxt.mem.wdata = s_r.data;
                        s_nxt.mem.wr = 1'b1;
                    end
                    cmm_pkg::OP_MVWR: begin
                        // destination write in Q4 only, W kept internal
                        s_nxt.mem.addr = s_r.dst;
                        s_nxt.mem.wdata = s_r.data;
                        s_nxt.mem.wr = !is_w_addr(s_r.dst);
                    end
                    default: begin
                        s_nxt.prod = s_r.prod;
                    end
                endcase
            end
            // write result; no status flag exists to touch
            cmm_pkg::Q4: begin
                s_nxt.mem.wr = 1'b0;
                case (s_r.op)
                    cmm_pkg::OP_LBSR: begin
                        // top bits never written high
                        s_nxt.bank_select_register = bank_value(s_r.data);
                    end
                    cmm_pkg::OP_LWREG: begin
                        // literal lands in W at the end of the cycle
                        s_nxt.w = s_r.data;
                    end
                    cmm_pkg::OP_LMUL: begin
                        // both bytes written together, W left alone
                        s_nxt.prod_hi = s_r.prod[15:8];
                        s_nxt.prod_lo = s_r.prod[7:0];
                    end
                    cmm_pkg::OP_MVWR: begin
                        if (is_w_addr(s_r.dst)) begin
                            s_nxt.w = s_r.data;
                        end
                        s_nxt.mv = cmm_pkg::MV_IDLE;
                        s_nxt.busy = 1'b0;
                    end
                    default: begin
                        s_nxt.w = s_r.w;
                    end
                endcase
            end
            default: begin
                s_nxt.q = cmm_pkg::Q1;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            // sequencing and working copies
            s_r.q <= cmm_pkg::Q1;
            s_r.op <= cmm_pkg::OP_NONE;
            s_r.mv <= cmm_pkg::MV_IDLE;
            s_r.lit <= 8'h00;
            s_r.src <= 14'h0000;
            s_r.dst <= 14'h0000;
            s_r.data <= 8'h00;
            s_r.prod <= 16'h0000;
            // architectural registers, memory request and status flags
            s_r.w <= cmm_pkg::W_RST;
            s_r.bank_select_register <= cmm_pkg::BSR_RST;
            s_r.prod_hi <= cmm_pkg::PROD_RST;
            s_r.prod_lo <= cmm_pkg::PROD_RST;
            s_r.mem <= '0;
            s_r.busy <= 1'b0;
            s_r.unknown <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign mem_req_o = s_r.mem;
    assign w_o = s_r.w;
    assign bsr_o = s_r.bank_select_register;
    assign prod_hi_o = s_r.prod_hi;
    assign prod_lo_o = s_r.prod_lo;
    assign q_phase_o = s_r.q;
    assign busy_o = s_r.busy;
    assign unknown_o = s_r.unknown;

endmodule : cmm_core

// file: include/cmm_pkg.sv
// shared constants and types for the move and multiply executor
package cmm_pkg;

    // quarter phases of one instruction cycle
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    // opcode fields of the single-word instructions and of the long move words
    localparam logic [7:0] OPC_LBSR = 8'h01;
    localparam logic [7:0] OPC_LWREG = 8'h0E;
    localparam logic [7:0] OPC_LMUL = 8'h0D;
    localparam logic [6:0] OPC_SWREG = 7'h37;
    localparam logic [11:0] OPC_MV1 = 12'h006;
    localparam logic [3:0] OPC_MVCONT = 4'hF;

    // addressing constants
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [5:0] ACC_LO_PAGE = 6'h00;
    localparam logic [5:0] ACC_HI_PAGE = 6'h3F;
    localparam logic [13:0] W_ADDR = 14'h3FE8;

    // reset values
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] BSR_RST = 8'h00;
    localparam logic [7:0] PROD_RST = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE, OP_LBSR, OP_LWREG, OP_SWREG, OP_LMUL, OP_MVRD, OP_MVWR
    } cmm_op_t;

    typedef enum logic [1:0] {
        MV_IDLE, MV_WORD2, MV_WORD3
    } cmm_mv_t;

    // data memory request
    typedef struct packed {
        logic [13:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cmm_mem_req_t;

    // whole executor state
    typedef struct packed {
        logic [1:0] q;
        cmm_op_t op;
        cmm_mv_t mv;
        logic [7:0] lit;
        logic [13:0] src;
        logic [13:0] dst;
        logic [7:0] data;
        logic [15:0] prod;
        logic [7:0] w;
        logic [7:0] bank_select_register;
        logic [7:0] prod_hi;
        logic [7:0] prod_lo;
        cmm_mem_req_t mem;
        logic busy;
        logic unknown;
    } cmm_state_t;

endpackage : cmm_pkg

// file: verif/cmm_core_monitor.sv
// concurrent checks on the move and multiply executor ports
`timescale 1ns/1ps

module cmm_core_monitor (
    // clock and reset
    input logic mclk_i,
    input logic rst_i,
    // instruction side
    input logic [15:0] instr_i,
    input logic instr_valid_i,
    // results
    input cmm_pkg::cmm_mem_req_t mem_req_o,
    input logic [7:0] w_o,
    input logic [7:0] bsr_o,
    input logic [7:0] prod_hi_o,
    input logic [7:0] prod_lo_o,
    input logic [1:0] q_phase_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // word accepted at the edge ending Q1
    logic tk;
    assign tk = q_phase_o == 2'h0 && instr_valid_i;

    // strobes confined to their quarter; bank select top bits low
    rd_in_q2_a: assert property (mem_req_o.rd |-> q_phase_o == 2'h1)
        else $error("read strobe outside Q2");
    wr_in_q4_a: assert property (mem_req_o.wr |-> q_phase_o == 2'h3)
        else $error("write strobe outside Q4");
    bsr_top_zero_a: assert property (bsr_o[7:6] == 2'b00)
        else $error("bank select top bits set");
    // registers only move at the edge ending Q4
    w_at_q4_a: assert property ($changed(w_o) |-> q_phase_o == 2'h0)
        else $error("working register changed off Q4");
    bsr_at_q4_a: assert property ($changed(bsr_o) |-> q_phase_o == 2'h0)
        else $error("bank select changed off Q4");
    prod_at_q4_a: assert property ($changed({prod_hi_o, prod_lo_o})
        |-> $past(q_phase_o) == 2'h3)
        else $error("product changed off Q4");
    // results four edges after acceptance
    wload_val_a: assert property (tk && instr_i[15:8] == 8'h0E
        |-> ##4 w_o == $past(instr_i[7:0], 4))
        else $error("working register load wrong");
    bload_val_a: assert property (tk && instr_i[15:6] == 10'h004
        |-> ##4 bsr_o == {2'b00, $past(instr_i[5:0], 4)})
        else $error("bank select load wrong");
    mul_val_a: assert property (tk && instr_i[15:8] == 8'h0D
        |-> ##4 ({prod_hi_o, prod_lo_o}
        == 16'($past(w_o, 4)) * 16'($past(instr_i[7:0], 4))) && $stable(w_o))
        else $error("literal multiply wrong");

    // main scenarios reached
    cover property (tk && instr_i[15:8] == 8'h0D);
    cover property (tk && instr_i[15:9] == 7'h37);
    cover property (tk && instr_i[15:4] == 12'h006);
endmodule : cmm_core_monitor

bind cmm_core cmm_core_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .mem_req_o(mem_req_o), .w_o(w_o), .bsr_o(bsr_o),
    .prod_hi_o(prod_hi_o), .prod_lo_o(prod_lo_o), .q_phase_o(q_phase_o));

// file: verif/cmm_core_tb_top.sv
// self-checking random bench for the move and multiply executor
`timescale 1ns/1ps

module cmm_core_tb_top;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic ext_set_en_i = 1'b0;
    logic [13:0] idx_base_i = 14'h0000;
    logic [7:0] mem_rdata_i;
    cmm_pkg::cmm_mem_req_t mem_req_o;
    logic [7:0] w_o, bsr_o, prod_hi_o, prod_lo_o, k, mw, mb;
    logic [1:0] q_phase_o;
    logic busy_o, unknown_o;
    logic [13:0] s, d;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    integer seed = 32'h15f94468;

    cmm_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .ext_set_en_i(ext_set_en_i), .idx_base_i(idx_base_i),
        .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .w_o(w_o), .bsr_o(bsr_o),
        .prod_hi_o(prod_hi_o), .prod_lo_o(prod_lo_o), .q_phase_o(q_phase_o),
        .busy_o(busy_o), .unknown_o(unknown_o));

    // memory contents as a pattern of the address
    function automatic logic [7:0] pat(input logic [13:0] a);
        return a[7:0] ^ {2'b00, a[13:8]} ^ 8'hA5;
    endfunction : pat

    // combinational memory, inverted data while not read
    assign mem_rdata_i = mem_req_o.rd ? pat(mem_req_o.addr) : ~pat(mem_req_o.addr);

    // expected file address of a store
    function automatic logic [13:0] eaddr(input logic [7:0] f, input logic a);
        if (a) return {mb[5:0], f};
        if (ext_set_en_i && f <= 8'h5F) return idx_base_i + {6'h00, f};
        return {(f < 8'h60) ? 6'h00 : 6'h3F, f};
    endfunction : eaddr

    // clock and timeout
    initial forever #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task results;
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    task chk(input string n, input logic [15:0] e, input logic [15:0] v);
        checks++;
        if (e !== v) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, v);
        end
    endtask : chk

    task to_q(input logic [1:0] ph);
        @(negedge mclk_i);
        while (q_phase_o !== ph) @(negedge mclk_i);
    endtask : to_q

    // offer one word for the next Q1, return at its accepting edge
    task issue(input logic [15:0] wd);
        to_q(2'h3);
        @(posedge mclk_i);
        instr_i <= wd;
        instr_valid_i <= 1'b1;
        ext_set_en_i <= $random(seed);
        idx_base_i <= $random(seed);
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
    endtask : issue

    task run(input logic [15:0] wd);
        issue(wd);
        to_q(2'h3);
        @(posedge mclk_i);
        #1;
    endtask : run

    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        run(16'h0EE2);
        mw = 8'hE2;
        run(16'h0DC4);
        chk("prod", 16'hAD08, {prod_hi_o, prod_lo_o});
        run(16'h013F);
        mb = 8'h3F;
        chk("bsr_o", 16'h003F, {8'h00, bsr_o});
        for (int i = 0; i < 60; i++) begin
            k = $random(seed);
            s = $random(seed);
            d = $random(seed);
            if (s == 14'h3FE8) s = 14'h0123;
            if (d == 14'h3FE8) d = 14'h2000;
            case (i % 5)
                0: begin
                    run({8'h0E, k});
                    mw = k;
                    chk("w_o", {8'h00, mw}, {8'h00, w_o});
                end
                1: begin
                    run({10'h004, k[5:0]});
                    mb = {2'b00, k[5:0]};
                    chk("bsr_o", {8'h00, mb}, {8'h00, bsr_o});
                end
                2: begin
                    run({8'h0D, k});
                    chk("prod", 16'(mw) * 16'(k), {prod_hi_o, prod_lo_o});
                    chk("w_o", {8'h00, mw}, {8'h00, w_o});
                end
                3: begin
                    issue({7'h37, s[8], k});
                    to_q(2'h3);
                    chk("wr", 16'h0001, {15'h0000, mem_req_o.wr});
                    chk("addr", {2'b00, eaddr(k, s[8])}, {2'b00, mem_req_o.addr});
                    chk("wdata", {8'h00, mw}, {8'h00, mem_req_o.wdata});
                end
                default: begin
                    issue({12'h006, s[13:10]});
                    issue({4'hF, s[9:0], d[13:12]});
                    to_q(2'h1);
                    chk("rd", 16'h0001, {15'h0000, mem_req_o.rd});
                    chk("rd addr", {2'b00, s}, {2'b00, mem_req_o.addr});
                    issue({4'hF, d[11:0]});
                    to_q(2'h3);
                    chk("mv wr", 16'h0002, {14'h0000, mem_req_o.wr, mem_req_o.rd});
                    chk("wr addr", {2'b00, d}, {2'b00, mem_req_o.addr});
                    chk("mv data", {8'h00, pat(s)}, {8'h00, mem_req_o.wdata});
                end
            endcase
        end
        // corner: refused bank number leaves bank select alone
        issue(16'h01C5);
        #1;
        chk("unknown_o", 16'h0001, {15'h0000, unknown_o});
        to_q(2'h3);
        @(posedge mclk_i);
        #1;
        chk("bsr_o", {8'h00, mb}, {8'h00, bsr_o});
        // corner: W as move source, no memory read
        issue(16'h006F);
        #1;
        chk("busy_o", 16'h0001, {15'h0000, busy_o});
        issue({4'hF, 10'h3E8, 2'h0});
        to_q(2'h1);
        chk("rd w", 16'h0000, {15'h0000, mem_req_o.rd});
        issue(16'hF155);
        to_q(2'h3);
        chk("w src data", {8'h00, mw}, {8'h00, mem_req_o.wdata});
        @(posedge mclk_i);
        #1;
        chk("busy_o", 16'h0000, {15'h0000, busy_o});
        // corner: W as move destination, no memory write
        issue(16'h0060);
        issue({4'hF, 10'h123, 2'h3});
        issue(16'hFFE8);
        to_q(2'h3);
        chk("wr w", 16'h0000, {15'h0000, mem_req_o.wr});
        @(posedge mclk_i);
        #1;
        mw = pat(14'h0123);
        chk("w dst", {8'h00, mw}, {8'h00, w_o});
        results();
    end
endmodule : cmm_core_tb_top
